/* File: gkit_pkg.sv */
// Package with register map, field positions, reset values and timing constants
package gkit_pkg;

  // ==========================================================================
  // Bus geometry
  // ==========================================================================
  localparam int          WB_AW         = 8;
  localparam int          WB_DW         = 32;
  localparam int          REG_W         = 16;
  localparam logic [31:0] BLOCK_BASE    = 32'h5000_1400;

  // ==========================================================================
  // Register indices (byte address is four times the index above the base)
  // ==========================================================================
  localparam logic [31:0] OFS_CH_SEL0   = 32'h5000_1400;
  localparam logic [31:0] OFS_DEBOUNCE  = 32'h5000_140C;
  localparam logic [31:0] OFS_CLEAR     = 32'h5000_140E;
  localparam logic [31:0] OFS_TRIG_CTRL = 32'h5000_1410;
  localparam logic [31:0] OFS_KP_SEL0   = 32'h5000_1412;
  localparam logic [31:0] OFS_KP_SEL1   = 32'h5000_1414;
  localparam logic [31:0] OFS_KP_SEL2   = 32'h5000_1416;
  localparam logic [31:0] OFS_STATUS    = 32'h5000_1418;
  localparam logic [31:0] OFS_CH_STEP   = 32'h0000_0002;

  // ==========================================================================
  // Reset values and writable masks
  // ==========================================================================
  localparam logic [15:0] REG_RST       = 16'h0000;
  localparam logic [5:0]  CH_SEL_RST    = 6'h00;
  localparam logic [15:0] MASK_CH_SEL   = 16'h003F;
  localparam logic [15:0] MASK_DEBOUNCE = 16'h3F3F;
  localparam logic [15:0] MASK_CTRL     = 16'h1F1F;
  localparam logic [15:0] MASK_KP_SEL0  = 16'hFFFF;
  localparam logic [15:0] MASK_KP_SEL1  = 16'hFFFF;
  localparam logic [15:0] MASK_KP_SEL2  = 16'h00FF;

  // ==========================================================================
  // Field positions
  // ==========================================================================
  localparam int          NUM_CH        = 5;
  localparam int          SEL_W         = 6;
  localparam int          NUM_PINS      = 32;
  localparam int          CTRL_LOW_LSB  = 0;
  localparam int          CTRL_REARM_LSB = 8;
  localparam int          KP_REL_BIT    = 15;
  localparam int          KP_LOW_BIT    = 14;
  localparam int          KP_REP_LSB    = 8;
  localparam int          KP_REP_W      = 6;
  localparam int          KP_P1_LSB     = 10;
  localparam int          DEB_VAL_LSB   = 0;
  localparam int          DEB_EN_LSB    = 8;
  localparam int          DEB_EN_KP_BIT = 13;
  localparam int          CLR_KP_BIT    = 5;
  localparam int          STAT_KP_BIT   = 5;
  localparam int          STAT_KEY_BIT  = 6;

  // ==========================================================================
  // Timing
  // ==========================================================================
  localparam int          CLK_PERIOD_NS = 10;
  localparam int          MS_PERIOD_NS  = 1_000_000;
  localparam int          MS_CYCLES_DEF = MS_PERIOD_NS / CLK_PERIOD_NS;

  // Byte address of a printed register index
  function automatic logic [WB_AW-1:0] gkit_addr(input logic [31:0] ofs);
    logic [31:0] d;
    d = (ofs - BLOCK_BASE) << 2;
    return d[WB_AW-1:0];
  endfunction

endpackage

/* File: gkit_ms_tick.sv */
// Millisecond tick divider
`timescale 1ns/1ps
module gkit_ms_tick
  import gkit_pkg::*;
#(
  parameter int MS_CYCLES = MS_CYCLES_DEF
)
(
  input  wire logic clk_i,
  input  wire logic rst_i,
  output logic      tick_o
);
  localparam int          CW   = $clog2(MS_CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(MS_CYCLES - 1);

  logic [CW-1:0] cnt_reg;
  logic          tick_reg;
  wire           wrap = (cnt_reg == LAST);

  // ==========================================================================
  // Counter
  // ==========================================================================
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cnt_reg  <= '0;
      tick_reg <= 1'b0;
    end
    else
    begin
      cnt_reg  <= wrap ? '0 : cnt_reg + CW'(1);
      tick_reg <= wrap;
    end
  end

  assign tick_o = tick_reg;
endmodule

/* File: gkit_debounce.sv */
// Debounce filter in millisecond units
`timescale 1ns/1ps
module gkit_debounce
  import gkit_pkg::*;
(
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             tick_i,
  input  wire logic             en_i,
  input  wire logic [KP_REP_W-1:0] period_i,
  input  wire logic             raw_i,
  output logic                  stable_o
);
  logic [KP_REP_W-1:0] cnt_reg;
  logic                stable_reg;

  wire bypass  = ~en_i | (period_i == '0);
  wire differs = (raw_i != stable_reg);
  wire expired = tick_i & (cnt_reg + KP_REP_W'(1) >= period_i);

  // ==========================================================================
  // Level must differ for the whole period before it is taken
  // ==========================================================================
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cnt_reg    <= '0;
      stable_reg <= 1'b0;
    end
    else if (bypass | ~differs)
    begin
      cnt_reg    <= '0;
      stable_reg <= raw_i;
    end
    else if (expired)
    begin
      cnt_reg    <= '0;
      stable_reg <= raw_i;
    end
    else if (tick_i)
    begin
      cnt_reg <= cnt_reg + KP_REP_W'(1);
    end
  end

  assign stable_o = stable_reg;
endmodule

/* File: gkit_trigger.sv */
// GPIO channel and keypad interrupt trigger block with Wishbone registers
//
// Summary of operation
// - Channel 0 rearm bit 0 retriggers at once; 1 waits for release.
// - Channels 1 to 4 have own rearm bits in bits 9 to 12.
// - Channel 0 polarity 0 triggers on high input, 1 on low input.
// - Channels 1 to 4 have own polarity bits in bits 1 to 4.
// - Keypad release bit set adds a debounced interrupt on key release.
// - Keypad polarity 0 triggers enabled pins high, 1 triggers low.
// - Held key retriggers keypad interrupt every N ms, N from 1 to 63.
// - Repeat field zero stops the repeat timer entirely.
// - First keypad select bits 0 to 7 enable port 0 pins 0 to 7.
// - Second keypad select bits 10 to 15 enable port 1 pins 0 to 5.
// - Second keypad select bits 0 to 9 enable port 2 pins 0 to 9.
// - Third keypad select bits 0 to 7 enable port 3 pins 0 to 7.
// - Channel source is a 6-bit pin selector; zero selects no pin.
// - With debounce on, input must stay active N ms before triggering.
// - Writing 1 to a clear bit clears that interrupt; clear reads zero.
`timescale 1ns/1ps
module gkit_trigger
  import gkit_pkg::*;
#(
  parameter int MS_CYCLES = MS_CYCLES_DEF
)
(
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             wb_cyc_i,
  input  wire logic             wb_stb_i,
  input  wire logic             wb_we_i,
  input  wire logic [WB_AW-1:0] wb_adr_i,
  input  wire logic [3:0]       wb_sel_i,
  input  wire logic [WB_DW-1:0] wb_dat_i,
  output logic      [WB_DW-1:0] wb_dat_o,
  output logic                  wb_ack_o,
  input  wire logic [7:0]       port0_i,
  input  wire logic [5:0]       port1_i,
  input  wire logic [9:0]       port2_i,
  input  wire logic [7:0]       port3_i,
  output logic      [NUM_CH-1:0] gpio_irq_o,
  output logic                  keypad_interrupt_o
);

  // ==========================================================================
  // Helpers
  // ==========================================================================
  function automatic logic [15:0] wr16(input logic [15:0] old, input logic [15:0] d,
                                       input logic [15:0] be, input logic [15:0] m);
    return (old & ~(be & m)) | (d & be & m);
  endfunction

  function automatic logic pin_active(input logic [SEL_W-1:0] s,
                                      input logic [NUM_PINS-1:0] p, input logic low);
    logic [SEL_W-1:0] idx;
    idx = s - SEL_W'(1);
    if (s == '0 || s > SEL_W'(NUM_PINS))
      return 1'b0;
    return p[idx[4:0]] ^ low;
  endfunction

  // ==========================================================================
  // Registers and state
  // ==========================================================================
  logic [15:0]       trig_ctrl_reg;
  logic [15:0]       kp_sel0_reg;
  logic [15:0]       kp_sel1_reg;
  logic [15:0]       kp_sel2_reg;
  logic [15:0]       debounce_reg;
  logic [SEL_W-1:0]  ch_sel_reg [NUM_CH];
  logic              ack_reg;
  logic [WB_DW-1:0]  rdata_reg;
  logic [NUM_PINS-1:0] pin_meta_reg;
  logic [NUM_PINS-1:0] pin_sync_reg;
  logic [NUM_CH-1:0] ch_pend_reg;
  logic [NUM_CH-1:0] ch_armed_reg;
  logic              kp_pend_reg;
  logic              kp_armed_reg;
  logic              kp_prev_reg;
  logic [KP_REP_W-1:0] rep_cnt_reg;
  logic [15:0]       rdata_next;
  logic              ms_tick;
  logic [NUM_CH-1:0] ch_deb;
  logic              kp_deb;

  // ==========================================================================
  // Bus decode
  // ==========================================================================
  wire        req     = wb_cyc_i & wb_stb_i & ~ack_reg;
  wire        wr_stb  = req & wb_we_i;
  wire [15:0] be16    = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  wire [15:0] wd16    = wb_dat_i[15:0];
  wire        hit_deb = (wb_adr_i == gkit_addr(OFS_DEBOUNCE));
  wire        hit_clr = (wb_adr_i == gkit_addr(OFS_CLEAR));
  wire        hit_ctl = (wb_adr_i == gkit_addr(OFS_TRIG_CTRL));
  wire        hit_k0  = (wb_adr_i == gkit_addr(OFS_KP_SEL0));
  wire        hit_k1  = (wb_adr_i == gkit_addr(OFS_KP_SEL1));
  wire        hit_k2  = (wb_adr_i == gkit_addr(OFS_KP_SEL2));
  wire        hit_st  = (wb_adr_i == gkit_addr(OFS_STATUS));
  wire [5:0]  clr_vec = (wr_stb & hit_clr) ? (wd16[5:0] & {6{wb_sel_i[0]}}) : 6'h00;

  // ==========================================================================
  // Register writes
  // ==========================================================================
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      trig_ctrl_reg <= REG_RST;
      kp_sel0_reg   <= REG_RST;
      kp_sel1_reg   <= REG_RST;
      kp_sel2_reg   <= REG_RST;
      debounce_reg  <= REG_RST;
      for (int i = 0; i < NUM_CH; i++)
        ch_sel_reg[i] <= CH_SEL_RST;
    end
    else if (wr_stb)
    begin
      if (hit_ctl)
        trig_ctrl_reg <= wr16(trig_ctrl_reg, wd16, be16, MASK_CTRL);
      if (hit_k0)
        kp_sel0_reg <= wr16(kp_sel0_reg, wd16, be16, MASK_KP_SEL0);
      if (hit_k1)
        kp_sel1_reg <= wr16(kp_sel1_reg, wd16, be16, MASK_KP_SEL1);
      if (hit_k2)
        kp_sel2_reg <= wr16(kp_sel2_reg, wd16, be16, MASK_KP_SEL2);
      if (hit_deb)
        debounce_reg <= wr16(debounce_reg, wd16, be16, MASK_DEBOUNCE);
      for (int i = 0; i < NUM_CH; i++)
        if (wb_adr_i == gkit_addr(OFS_CH_SEL0 + OFS_CH_STEP * 32'(i)) && wb_sel_i[0])
          ch_sel_reg[i] <= wd16[SEL_W-1:0];
    end
  end

  // ==========================================================================
  // Read mux and acknowledge
  // ==========================================================================
  always_comb
  begin
    rdata_next = 16'h0000;
    for (int i = 0; i < NUM_CH; i++)
      if (wb_adr_i == gkit_addr(OFS_CH_SEL0 + OFS_CH_STEP * 32'(i)))
        rdata_next = {10'h000, ch_sel_reg[i]};
    if (hit_deb)
      rdata_next = debounce_reg;
    if (hit_clr)
      rdata_next = 16'h0000;
    if (hit_ctl)
      rdata_next = trig_ctrl_reg;
    if (hit_k0)
      rdata_next = kp_sel0_reg;
    if (hit_k1)
      rdata_next = kp_sel1_reg;
    if (hit_k2)
      rdata_next = kp_sel2_reg;
    if (hit_st)
      rdata_next = {9'h000, kp_deb, kp_pend_reg, ch_pend_reg};
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_reg   <= 1'b0;
      rdata_reg <= '0;
    end
    else
    begin
      ack_reg   <= req;
      rdata_reg <= req ? {16'h0000, rdata_next} : rdata_reg;
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rdata_reg;

  // ==========================================================================
  // Pin synchronisers, port order P0, P1, P2, P3 from bit 0 upward
  // ==========================================================================
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pin_meta_reg <= '0;
      pin_sync_reg <= '0;
    end
    else
    begin
      pin_meta_reg <= {port3_i, port2_i, port1_i, port0_i};
      pin_sync_reg <= pin_meta_reg;
    end
  end

  gkit_ms_tick #(
    .MS_CYCLES (MS_CYCLES)
  ) u_tick (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .tick_o (ms_tick)
  );

  wire [KP_REP_W-1:0] deb_val = debounce_reg[DEB_VAL_LSB +: KP_REP_W];

  // ==========================================================================
  // GPIO channels
  // ==========================================================================
  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++)
    begin : g_ch
      wire low   = trig_ctrl_reg[CTRL_LOW_LSB + g];
      wire rearm = trig_ctrl_reg[CTRL_REARM_LSB + g];
      wire raw   = pin_active(ch_sel_reg[g], pin_sync_reg, low);

      gkit_debounce u_deb (
        .clk_i    (clk_i),
        .rst_i    (rst_i),
        .tick_i   (ms_tick),
        .en_i     (debounce_reg[DEB_EN_LSB + g]),
        .period_i (deb_val),
        .raw_i    (raw),
        .stable_o (ch_deb[g])
      );

      wire set = ch_deb[g] & ch_armed_reg[g];

      always_ff @(posedge clk_i)
      begin
        if (rst_i)
        begin
          ch_pend_reg[g]  <= 1'b0;
          ch_armed_reg[g] <= 1'b1;
        end
        else
        begin
          ch_pend_reg[g] <= (ch_pend_reg[g] & ~clr_vec[g]) | set;
          if (~rearm | ~ch_deb[g])
            ch_armed_reg[g] <= 1'b1;
          else if (set)
            ch_armed_reg[g] <= 1'b0;
        end
      end
    end
  endgenerate

  assign gpio_irq_o = ch_pend_reg;

  // ==========================================================================
  // Keypad source
  // ==========================================================================
  wire [NUM_PINS-1:0] kp_en = {kp_sel2_reg[7:0],
                               kp_sel1_reg[9:0],
                               kp_sel1_reg[15:KP_P1_LSB],
                               kp_sel0_reg[7:0]};
  wire kp_low = kp_sel0_reg[KP_LOW_BIT];
  wire kp_raw = |(kp_en & (pin_sync_reg ^ {NUM_PINS{kp_low}}));

  gkit_debounce u_kp_deb (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .tick_i   (ms_tick),
    .en_i     (debounce_reg[DEB_EN_KP_BIT]),
    .period_i (deb_val),
    .raw_i    (kp_raw),
    .stable_o (kp_deb)
  );

  wire [KP_REP_W-1:0] rep_n = kp_sel0_reg[KP_REP_LSB +: KP_REP_W];
  wire rep_on   = kp_deb & (rep_n != '0);
  wire rep_fire = rep_on & ms_tick & (rep_cnt_reg + KP_REP_W'(1) >= rep_n);
  wire rel_evt  = kp_prev_reg & ~kp_deb & kp_sel0_reg[KP_REL_BIT];
  wire kp_set   = (kp_deb & kp_armed_reg) | rel_evt;

  // ==========================================================================
  // Keypad pending, arming and repeat timer
  // ==========================================================================
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      kp_pend_reg  <= 1'b0;
      kp_armed_reg <= 1'b1;
      kp_prev_reg  <= 1'b0;
      rep_cnt_reg  <= '0;
    end
    else
    begin
      kp_prev_reg <= kp_deb;
      kp_pend_reg <= (kp_pend_reg & ~clr_vec[CLR_KP_BIT]) | kp_set;
      if (~kp_deb | rep_fire)
        kp_armed_reg <= 1'b1;
      else if (kp_set)
        kp_armed_reg <= 1'b0;
      if (~rep_on | rep_fire)
        rep_cnt_reg <= '0;
      else if (ms_tick)
        rep_cnt_reg <= rep_cnt_reg + KP_REP_W'(1);
    end
  end

  assign keypad_interrupt_o = kp_pend_reg;

endmodule

/* File: gkit_trigger_monitor.sv */
// Port checker for the GPIO and keypad trigger block
`timescale 1ns/1ps
module gkit_trigger_monitor
  import gkit_pkg::*;
#(
  parameter int MS_CYCLES = MS_CYCLES_DEF
)
(
  input wire logic              clk_i,
  input wire logic              rst_i,
  input wire logic              wb_cyc_i,
  input wire logic              wb_stb_i,
  input wire logic              wb_we_i,
  input wire logic [WB_AW-1:0]  wb_adr_i,
  input wire logic [3:0]        wb_sel_i,
  input wire logic [WB_DW-1:0]  wb_dat_i,
  input wire logic [WB_DW-1:0]  wb_dat_o,
  input wire logic              wb_ack_o,
  input wire logic [7:0]        port0_i,
  input wire logic [5:0]        port1_i,
  input wire logic [9:0]        port2_i,
  input wire logic [7:0]        port3_i,
  input wire logic [NUM_CH-1:0] gpio_irq_o,
  input wire logic              keypad_interrupt_o
);
  // ==========================================================================
  // Request decode
  wire logic req  = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire logic rdq  = req && !wb_we_i;
  wire logic clr  = wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[0] && wb_adr_i == 8'h38;
  wire logic clrk = clr && wb_dat_i[CLR_KP_BIT];
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // ==========================================================================
  // Assertions
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  a_ack_latency: assert property (req |=> wb_ack_o) else $error("ack missing");
  a_ack_cause: assert property ($rose(wb_ack_o) |-> $past(req)) else $error("stray ack");
  a_dat_upper: assert property (wb_ack_o |-> wb_dat_o[31:16] == 16'h0000)
    else $error("upper read data set");
  a_clear_reads_zero: assert property (rdq && wb_adr_i == 8'h38 |=> wb_dat_o == 32'h0)
    else $error("clear read not zero");
  a_unmapped_zero: assert property (rdq && wb_adr_i == 8'h04 |=> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  a_ctrl_reserved: assert property (rdq && wb_adr_i == 8'h40 |=> (wb_dat_o & 32'hE0E0) == 0)
    else $error("reserved ctrl bits set");
  a_kp_pending_hold: assert property ($fell(keypad_interrupt_o) |->
    $past(clrk) || $past(clrk, 2)) else $error("keypad pending lost");
  a_ch_pending_hold: assert property (|($past(gpio_irq_o) & ~gpio_irq_o) |->
    $past(clr) || $past(clr, 2)) else $error("channel pending lost");
  // ==========================================================================
  // Coverage
  c_kp_rise: cover property ($rose(keypad_interrupt_o));
  c_ch_rise: cover property ($rose(|gpio_irq_o));
  c_kp_clear: cover property (clrk && keypad_interrupt_o);
endmodule

bind gkit_trigger gkit_trigger_monitor #(.MS_CYCLES(MS_CYCLES)) u_mon (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .port0_i(port0_i), .port1_i(port1_i), .port2_i(port2_i),
  .port3_i(port3_i), .gpio_irq_o(gpio_irq_o), .keypad_interrupt_o(keypad_interrupt_o));

/* File: gkit_key_model.sv */
// Key and button pin model with contact bounce
`timescale 1ns/1ps
module gkit_key_model
(
  input  wire logic        clk_i,
  input  wire logic [31:0] keys_i,
  input  wire logic        low_i,
  input  wire logic [3:0]  bounce_i,
  output logic      [7:0]  port0_o,
  output logic      [5:0]  port1_o,
  output logic      [9:0]  port2_o,
  output logic      [7:0]  port3_o
);
  logic [31:0] lvl_reg  = 32'h0000_0000;
  logic [31:0] last_reg = 32'h0000_0000;
  logic [3:0]  cnt_reg  = 4'h0;
  // ==========================================================================
  // Contacts chatter for a while after each change
  always_ff @(posedge clk_i)
  begin
    last_reg <= keys_i;
    cnt_reg  <= (keys_i != last_reg) ? bounce_i : (cnt_reg != 4'h0) ? cnt_reg - 4'h1 : 4'h0;
    lvl_reg  <= cnt_reg[0] ? ~keys_i : keys_i;
  end
  assign {port3_o, port2_o, port1_o, port0_o} = low_i ? ~lvl_reg : lvl_reg;
endmodule

/* File: tb.sv */
// Register and interrupt tests for the trigger block
`timescale 1ns/1ps
module tb;
  import gkit_pkg::*;
  logic        clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, low = 1'b0;
  logic [7:0]  adr = 8'h00, p0, p3;
  logic [5:0]  p1;
  logic [9:0]  p2;
  logic [3:0]  sel = 4'h0, bnc = 4'h0;
  logic [31:0] dat = 32'h0, rdat, q, keys = 32'h0;
  logic [4:0]  gp;
  logic        ack, kp;
  logic [15:0] kcfg;
  int          error_cnt = 0, total_checks = 0;
  gkit_trigger #(.MS_CYCLES(10)) DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .port0_i(p0), .port1_i(p1), .port2_i(p2),
    .port3_i(p3), .gpio_irq_o(gp), .keypad_interrupt_o(kp));
  gkit_key_model u_keys (.clk_i(clk_i), .keys_i(keys), .low_i(low), .bounce_i(bnc),
    .port0_o(p0), .port1_o(p1), .port2_o(p2), .port3_o(p3));
  initial forever #5 clk_i = ~clk_i;
  // ==========================================================================
  // Bus and compare tasks
  task automatic summarize();
    if (error_cnt == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e)
    begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [15:0] d);
    int n;
    n = 0;
    {cyc, stb, we, adr, sel, dat} <= {2'b11, w, a, 4'h3, 16'h0000, d};
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (ack !== 1'b1 && n < 50);
    if (n >= 50) chk("ack", 32'h1, 32'h0);
    q = rdat;
    {cyc, stb} <= 2'b00;
    @(posedge clk_i);
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    wb(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 16'h0000);
    chk("register", e, q);
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic chg(input logic [4:0] e);
    chk("gpio_irq", {27'h0, e}, {27'h0, gp});
  endtask
  task automatic chkp(input logic e);
    chk("keypad_interrupt", {31'h0, e}, {31'h0, kp});
  endtask
  task automatic en_pin(input int i);
    logic [15:0] s0, s1, s2;
    {s0, s1, s2} = 48'h0;
    if (i < 8) s0[i] = 1'b1;
    else if (i < 14) s1[i + 2] = 1'b1;
    else if (i < 24) s1[i - 14] = 1'b1;
    else s2[i - 24] = 1'b1;
    wr(8'h48, s0 | kcfg);
    wr(8'h50, s1);
    wr(8'h58, s2);
  endtask
  // ==========================================================================
  // Test sequence
  initial
  begin
    logic [87:0] ra;
    logic [31:0] ma;
    logic [63:0] mv;
    logic [39:0] sv;
    ra = 88'h0008_1018_2030_3840_4850_58;
    ma = 32'h4048_5058;
    mv = 64'h1F1F_FFFF_FFFF_00FF;
    sv = 40'h20_190F_0901;
    kcfg = 16'h0000;
    wt(20);
    rst_i <= 1'b0;
    wt(2);
    for (int i = 0; i < 11; i++) rd(ra[8*i+:8], 32'h0);
    rd(8'h04, 32'h0);
    for (int i = 0; i < 4; i++)
    begin
      wr(ma[8*i+:8], 16'hFFFF);
      rd(ma[8*i+:8], {16'h0000, mv[16*i+:16]});
      wr(ma[8*i+:8], 16'h0000);
    end
    wr(8'h38, 16'hFFFF);
    rd(8'h38, 32'h0);
    for (int c = 0; c < 5; c++) wr(8'(8 * c), {8'h00, sv[8*c+:8]});
    for (int c = 0; c < 5; c++)
    begin
      keys <= 32'h1 << (sv[8*c+:8] - 8'h01);
      wt(8);
      chg(5'h01 << c);
      keys <= 32'h0;
      wt(8);
      wr(8'h38, 16'h001F);
      wt(2);
      chg(5'h00);
    end
    wr(8'h40, 16'h001F);
    wt(8);
    chg(5'h1F);
    keys <= 32'hFFFF_FFFF;
    wt(8);
    wr(8'h38, 16'h001F);
    wt(8);
    chg(5'h00);
    wr(8'h40, 16'h0200);
    keys <= 32'h0000_0101;
    wt(8);
    wr(8'h38, 16'h001C);
    wt(2);
    chg(5'h03);
    wr(8'h38, 16'h0003);
    wt(4);
    chg(5'h01);
    keys <= 32'h0000_0001;
    wt(8);
    keys <= 32'h0000_0101;
    wt(8);
    chg(5'h03);
    wr(8'h00, 16'h0000);
    keys <= 32'hFFFF_FFFF;
    wr(8'h38, 16'h001F);
    wt(8);
    chk("channel0", 32'h0, {31'h0, gp[0]});
    keys <= 32'h0;
    wr(8'h38, 16'h003F);
    for (int i = 0; i < 32; i++)
    begin
      en_pin(i);
      keys <= ~(32'h1 << i);
      wt(8);
      chkp(1'b0);
      keys <= 32'hFFFF_FFFF;
      wt(8);
      chkp(1'b1);
      keys <= 32'h0;
      wt(8);
      wr(8'h38, 16'h0020);
    end
    low <= 1'b1;
    kcfg = 16'h4000;
    en_pin(0);
    wt(8);
    wr(8'h38, 16'h0020);
    wt(4);
    chkp(1'b0);
    keys <= 32'h1;
    wt(8);
    chkp(1'b1);
    wr(8'h38, 16'h0020);
    keys <= 32'h0;
    wt(8);
    chkp(1'b0);
    kcfg = 16'hC000;
    en_pin(0);
    keys <= 32'h1;
    wt(8);
    wr(8'h38, 16'h0020);
    wt(100);
    chkp(1'b0);
    keys <= 32'h0;
    wt(8);
    chkp(1'b1);
    kcfg = 16'hC200;
    en_pin(0);
    keys <= 32'h1;
    wt(8);
    wr(8'h38, 16'h0020);
    wt(4);
    chkp(1'b0);
    wt(30);
    chkp(1'b1);
    {keys, low, bnc} <= {32'h0, 1'b0, 4'h5};
    kcfg = 16'h0000;
    en_pin(0);
    wr(8'h30, 16'h2003);
    wt(50);
    wr(8'h38, 16'h0020);
    keys <= 32'h1;
    wt(12);
    chkp(1'b0);
    wt(40);
    chkp(1'b1);
    rd(8'h60, 32'h0000_007E);
    summarize();
  end
  initial
  begin
    #400_000;
    error_cnt++;
    summarize();
  end
endmodule
